// ### hdl/pfc_defines.svh
// Purpose: constants for the page format controller
// Assumes: 50 MHz core clock
// Notes: offsets, defaults and counts
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH
// Register offsets
`define PFC_REG_CTRL 4'h0
`define PFC_REG_RMARGIN 4'h1
`define PFC_REG_LMARGIN 4'h2
`define PFC_REG_PAGELEN 4'h3
`define PFC_REG_TOPMARG 4'h4
`define PFC_REG_TEXTLEN 4'h5
`define PFC_REG_STATUS 4'h6
`define PFC_REG_LINE 4'h7
// Control field positions
`define PFC_CTRL_PERF 0
`define PFC_CTRL_AUTO 1
`define PFC_CTRL_SIZE_LO 2
`define PFC_CTRL_SIZE_HI 3
// Defaults and limits
`define PFC_RMARGIN_RST 8'h50
`define PFC_LMARGIN_RST 8'h01
`define PFC_MAX_EXP 8'h28
`define PFC_MAX_NORM 8'h50
`define PFC_MAX_COMP 8'h84
`define PFC_PAGELEN_AUTO 8'h41
`define PFC_PAGELEN_ROLL 8'h48
`define PFC_TOPMARG_AUTO 8'h02
`define PFC_TOPMARG_PERF 8'h02
`define PFC_TEXTLEN_AUTO 8'h3c
`define PFC_TEXTLEN_MAX 8'h9b
// Paper travel limit after a form feed, in lines (12 in)
`define PFC_FF_LIMIT_LINES 8'h48
`endif

// ### hdl/pfc_page_format.sv
// Purpose: page layout control for a thermal printer
// Assumes: commands arrive decoded from the escape parser
// Notes: one paper step per line_done handshake
//
// Overview of operation
// - Right margin limited to 40, 80 or 132 by print size.
// - Right margin left of left margin is ignored, old value kept.
// - Right margin is a head position, default 80.
// - Perforated mode form feed advances until top-of-form hole seen.
// - Perforated mode stops advancing after 12 inches without hole.
// - Host toggles auto paging; enabled splits output into pages.
// - Auto paging off prints continuously except perforated or form feed.
// - Auto paging on, perforated off: tick mark at each new page.
// - Page length accepted only in 1 to 255.
// - Auto off on roll paper uses fixed 72 line page.
// - Auto paging on defaults page length to 65.
// - Skip top margin on form feed and on text length overflow.
// - Top margin accepted 0 to 255, default 2 with auto paging.
// - Auto off on roll paper forces top margin to zero.
// - Perforated mode applies a top margin of at least 2.
// - Text length accepted only in 1 to 155.
// - Auto paging on defaults text length to 60.
// - Text length unused while auto paging is off.
// - Commands change current settings only, not power-on store.
`timescale 1ns/10ps
`include "pfc_defines.svh"
module pfc_page_format
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic cfg_reset,
	input wire logic cmd_rmargin,
	input wire logic cmd_auto,
	input wire logic cmd_pagelen,
	input wire logic cmd_textlen,
	input wire logic [7:0] cmd_value,
	input wire logic line_feed,
	input wire logic form_feed,
	input wire logic char_print,
	input wire logic tof_sense,
	input wire logic line_done,
	output logic paper_step,
	output logic tick_mark,
	output logic form_timeout,
	output logic feed_busy
);
	import pfc_pkg::*;

	// ========================================================
	// Sensor synchroniser
	logic tof_s1_q;
	logic tof_s2_q;
	logic tof_s3_q;
	logic tof_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tof_s1_q <= 1'b0;
			tof_s2_q <= 1'b0;
			tof_s3_q <= 1'b0;
			tof_q <= 1'b0;
		end
		else
		begin
			tof_s1_q <= tof_sense;
			tof_s2_q <= tof_s1_q;
			tof_s3_q <= tof_s2_q;
			if (tof_s2_q == tof_s3_q)
				tof_q <= tof_s3_q;
		end
	end

	// ========================================================
	// Current configuration
	logic perf_q;
	logic auto_q;
	pfc_size_t size_q;
	logic [7:0] rmargin_q;
	logic [7:0] lmargin_q;
	logic [7:0] pagelen_q;
	logic [7:0] topmarg_q;
	logic [7:0] textlen_q;
	logic wr_ctrl;
	logic [7:0] max_col;
	logic [7:0] rm_val;
	logic rm_req;
	logic [7:0] pl_val;
	logic pl_req;
	logic [7:0] tl_val;
	logic tl_req;
	logic tm_req;
	logic lm_req;
	logic auto_on;

	function automatic logic [7:0] size_max(input pfc_size_t s);
		unique case (s)
			PFC_SIZE_EXP: size_max = `PFC_MAX_EXP;
			PFC_SIZE_COMP: size_max = `PFC_MAX_COMP;
			default: size_max = `PFC_MAX_NORM;
		endcase
	endfunction : size_max

	// True when v lies within lo to hi, both ends included
	function automatic logic in_range
	(
		input logic [7:0] v,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	assign wr_ctrl = reg_wr && (reg_addr == `PFC_REG_CTRL);
	assign max_col = size_max(size_q);
	assign rm_req = cmd_rmargin || (reg_wr && reg_addr == `PFC_REG_RMARGIN);
	assign rm_val = cmd_rmargin ? cmd_value : reg_wdata;
	assign pl_req = cmd_pagelen
		|| (reg_wr && reg_addr == `PFC_REG_PAGELEN);
	assign pl_val = cmd_pagelen ? cmd_value : reg_wdata;
	assign tl_req = cmd_textlen
		|| (reg_wr && reg_addr == `PFC_REG_TEXTLEN);
	assign tl_val = cmd_textlen ? cmd_value : reg_wdata;
	assign tm_req = reg_wr && (reg_addr == `PFC_REG_TOPMARG);
	assign lm_req = reg_wr && (reg_addr == `PFC_REG_LMARGIN);
	assign auto_on = cmd_auto && cmd_value[0] && !auto_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			perf_q <= 1'b1;
			auto_q <= 1'b0;
			size_q <= PFC_SIZE_NORM;
		end
		else if (cfg_reset)
		begin
			perf_q <= 1'b1;
			auto_q <= 1'b0;
			size_q <= PFC_SIZE_NORM;
		end
		else if (cmd_auto)
			auto_q <= cmd_value[0];
		else if (wr_ctrl)
		begin
			perf_q <= reg_wdata[`PFC_CTRL_PERF];
			auto_q <= reg_wdata[`PFC_CTRL_AUTO];
			if (reg_wdata[`PFC_CTRL_SIZE_HI:`PFC_CTRL_SIZE_LO] != 2'b11)
				size_q <= pfc_size_t'(
					reg_wdata[`PFC_CTRL_SIZE_HI:`PFC_CTRL_SIZE_LO]);
		end
	end

	// Settings only touch current registers; no power-on store here
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rmargin_q <= `PFC_RMARGIN_RST;
			lmargin_q <= `PFC_LMARGIN_RST;
		end
		else if (cfg_reset)
		begin
			rmargin_q <= `PFC_RMARGIN_RST;
			lmargin_q <= `PFC_LMARGIN_RST;
		end
		else
		begin
			if (rm_req && in_range(rm_val, 8'h01, max_col)
				&& rm_val >= lmargin_q)
				rmargin_q <= rm_val;
			if (lm_req && in_range(reg_wdata, 8'h01, max_col)
				&& reg_wdata <= rmargin_q)
				lmargin_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pagelen_q <= `PFC_PAGELEN_AUTO;
			topmarg_q <= `PFC_TOPMARG_AUTO;
			textlen_q <= `PFC_TEXTLEN_AUTO;
		end
		else if (cfg_reset || auto_on)
		begin
			pagelen_q <= `PFC_PAGELEN_AUTO;
			topmarg_q <= `PFC_TOPMARG_AUTO;
			textlen_q <= `PFC_TEXTLEN_AUTO;
		end
		else
		begin
			if (pl_req && pl_val != 8'h00)
				pagelen_q <= pl_val;
			if (tm_req)
				topmarg_q <= reg_wdata;
			if (tl_req && in_range(tl_val, 8'h01, `PFC_TEXTLEN_MAX))
				textlen_q <= tl_val;
		end
	end

	// ========================================================
	// Effective page geometry
	logic [7:0] eff_page;
	logic [7:0] eff_top;
	always_comb
	begin
		eff_page = pagelen_q;
		eff_top = topmarg_q;
		if (!auto_q && !perf_q)
		begin
			eff_page = `PFC_PAGELEN_ROLL;
			eff_top = 8'h00;
		end
		if (perf_q && eff_top < `PFC_TOPMARG_PERF)
			eff_top = `PFC_TOPMARG_PERF;
	end

	// ========================================================
	// Paper motion sequencer
	pfc_state_t state_q;
	logic [7:0] line_q;
	logic [7:0] text_q;
	logic [7:0] steps_q;
	logic [7:0] travel_q;
	logic timeout_q;
	logic tick_q;
	logic overflow;
	logic page_end;
	logic page_evt;
	logic skip_arm;
	logic step_live;

	// Text length only counts with auto paging on
	assign overflow = auto_q && char_print && text_q >= textlen_q;
	assign page_end = (auto_q || perf_q) && line_q >= eff_page - 8'h01;
	assign page_evt = form_feed || overflow || (line_feed && page_end);
	// Roll paper skips at once; perforated paper seeks the hole first
	assign skip_arm = (state_q == PFC_IDLE) && page_evt && !perf_q
		&& (form_feed || auto_q);
	assign paper_step = step_live && line_done;
	assign feed_busy = state_q != PFC_IDLE;
	assign tick_mark = tick_q;
	assign form_timeout = timeout_q;

	// Only acknowledge a line that really moves paper
	always_comb
	begin
		step_live = 1'b0;
		unique case (state_q)
			PFC_IDLE: step_live = 1'b0;
			PFC_FORM: step_live = 1'b1;
			PFC_SKIP: step_live = steps_q != 8'h00;
			default: step_live = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tick_q <= 1'b0;
		else
			tick_q <= skip_arm && auto_q;
	end

	// Set when the hole search gives up; next feed clears it
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			timeout_q <= 1'b0;
		else if (state_q == PFC_IDLE && page_evt)
			timeout_q <= 1'b0;
		else if (state_q == PFC_FORM && !tof_q
			&& travel_q >= `PFC_FF_LIMIT_LINES)
			timeout_q <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= PFC_IDLE;
			line_q <= 8'h00;
			text_q <= 8'h00;
			steps_q <= 8'h00;
			travel_q <= 8'h00;
		end
		else
		begin
			unique case (state_q)
				PFC_IDLE:
				begin
					if (page_evt)
					begin
						travel_q <= 8'h00;
						if (perf_q)
							state_q <= PFC_FORM;
						else if (skip_arm)
						begin
							line_q <= 8'h00;
							text_q <= 8'h00;
							steps_q <= eff_top;
							state_q <= PFC_SKIP;
						end
						else
							line_q <= 8'h00;
					end
					else if (line_feed)
					begin
						line_q <= line_q + 8'h01;
						if (auto_q && line_q >= eff_top)
							text_q <= text_q + 8'h01;
					end
				end
				PFC_FORM:
				begin
					if (tof_q)
					begin
						line_q <= 8'h00;
						text_q <= 8'h00;
						steps_q <= eff_top;
						state_q <= PFC_SKIP;
					end
					else if (travel_q >= `PFC_FF_LIMIT_LINES)
						state_q <= PFC_IDLE;
					else if (line_done)
						travel_q <= travel_q + 8'h01;
				end
				PFC_SKIP:
				begin
					if (steps_q == 8'h00)
						state_q <= PFC_IDLE;
					else if (line_done)
					begin
						steps_q <= steps_q - 8'h01;
						line_q <= line_q + 8'h01;
					end
				end
				default: state_q <= PFC_IDLE;
			endcase
		end
	end

	// ========================================================
	// Register read port
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				`PFC_REG_CTRL: reg_rdata <= {4'h0, size_q, auto_q, perf_q};
				`PFC_REG_RMARGIN: reg_rdata <= rmargin_q;
				`PFC_REG_LMARGIN: reg_rdata <= lmargin_q;
				`PFC_REG_PAGELEN: reg_rdata <= eff_page;
				`PFC_REG_TOPMARG: reg_rdata <= eff_top;
				`PFC_REG_TEXTLEN: reg_rdata <= textlen_q;
				`PFC_REG_STATUS: reg_rdata <= {5'h00, timeout_q, state_q};
				`PFC_REG_LINE: reg_rdata <= line_q;
				default: reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end
endmodule : pfc_page_format

// ### hdl/pfc_pkg.sv
// Purpose: types for the page format controller
// Assumes: nothing
// Notes: print sizes and feed states
package pfc_pkg;
	typedef enum logic [1:0]
	{
		PFC_SIZE_NORM = 2'b00,
		PFC_SIZE_EXP = 2'b01,
		PFC_SIZE_COMP = 2'b10
	} pfc_size_t;
	typedef enum logic [1:0]
	{
		PFC_IDLE = 2'b00,
		PFC_FORM = 2'b01,
		PFC_SKIP = 2'b10
	} pfc_state_t;
endpackage : pfc_pkg

// ### sim/pfc_mech_model.sv
// Purpose: paper mechanism with top-of-form sensor
// Assumes: one line moved every gap+1 cycles while busy
// Notes: hole_at 0 means no hole on the paper
`timescale 1ns/10ps
module pfc_mech_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic feed_busy,
	input wire logic [7:0] hole_at,
	input wire logic [7:0] gap,
	output logic line_done,
	output logic tof_sense
);
	logic [7:0] n_q;
	logic [7:0] w_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			n_q <= 8'h00;
			w_q <= 8'h00;
			line_done <= 1'b0;
		end
		else
		begin
			line_done <= 1'b0;
			w_q <= w_q + 8'h01;
			if (!feed_busy)
			begin
				w_q <= 8'h00;
				n_q <= 8'h00;
			end
			else if (w_q == gap)
			begin
				w_q <= 8'h00;
				line_done <= 1'b1;
				n_q <= n_q + 8'h01;
			end
		end
	end
	// Hole passes the sensor during one line
	assign tof_sense = (hole_at != 8'h00) && (n_q == hole_at);
endmodule : pfc_mech_model

// ### sim/pfc_page_format_checker.sv
// Purpose: port assertions for pfc_page_format
// Assumes: one clock, async active-low reset
// Notes: bound to the top module
`timescale 1ns/10ps
module pfc_page_format_checker
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic line_feed,
	input wire logic form_feed,
	input wire logic char_print,
	input wire logic line_done,
	input wire logic paper_step,
	input wire logic tick_mark,
	input wire logic form_timeout,
	input wire logic feed_busy
);
	import pfc_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_step_busy: assert property (paper_step |-> feed_busy && line_done)
		else $error("paper step outside a feed");
	a_busy_cause: assert property
		($rose(feed_busy) |-> $past(form_feed || line_feed || char_print))
		else $error("feed started without a page event");
	a_tick_one: assert property (tick_mark |=> !tick_mark)
		else $error("tick mark longer than one cycle");
	a_tick_cause: assert property
		(tick_mark |-> $past(form_feed || line_feed || char_print))
		else $error("tick mark without a page event");
	a_tick_busy: assert property (tick_mark |-> feed_busy)
		else $error("tick mark without a skip");
	a_rm_range: assert property
		(reg_rd && reg_addr == 4'h1 |=> reg_rdata inside {[8'h01:8'h84]})
		else $error("right margin out of range");
	a_pl_range: assert property
		(reg_rd && reg_addr == 4'h3 |=> reg_rdata != 8'h00)
		else $error("page length zero");
	a_to_cause: assert property
		($rose(form_timeout) |-> $past(feed_busy))
		else $error("timeout outside a form feed");
	a_rd_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without a read");
endmodule : pfc_page_format_checker
bind pfc_page_format pfc_page_format_checker u_chk
(
	.clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .line_feed,
	.form_feed, .char_print, .line_done, .paper_step, .tick_mark,
	.form_timeout, .feed_busy
);

// ### sim/pfc_page_format_tb.sv
// Purpose: self-checking bench for pfc_page_format
// Assumes: 50 MHz clock, events as one-cycle pulses
// Notes: evt bits: cfg, rmargin, auto, pagelen, textlen, lf, ff, char
`timescale 1ns/10ps
module pfc_page_format_tb;
	import pfc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [7:0] evt = 8'h00;
	logic [7:0] cmd_value = 8'h00;
	logic [7:0] hole_at = 8'h00;
	logic [7:0] gap = 8'h06;
	logic tof_sense, line_done, paper_step, tick_mark, form_timeout, feed_busy;
	int fail_count = 0;
	int n_compared = 0;
	always #10 clk = ~clk;
	pfc_page_format u_dut
	(
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cfg_reset(evt[0]), .cmd_rmargin(evt[1]), .cmd_auto(evt[2]),
		.cmd_pagelen(evt[3]), .cmd_textlen(evt[4]), .cmd_value(cmd_value),
		.line_feed(evt[5]), .form_feed(evt[6]), .char_print(evt[7]),
		.tof_sense(tof_sense), .line_done(line_done),
		.paper_step(paper_step), .tick_mark(tick_mark),
		.form_timeout(form_timeout), .feed_busy(feed_busy)
	);
	pfc_mech_model u_mech
	(
		.clk(clk), .rst_n(rst_n), .feed_busy(feed_busy), .hole_at(hole_at),
		.gap(gap), .line_done(line_done), .tof_sense(tof_sense)
	);
	// ====
	// Shared tasks
	task summarize;
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rc
	task ev(input int i, input logic [7:0] v);
		@(posedge clk);
		evt[i] <= 1'b1;
		cmd_value <= v;
		@(posedge clk);
		evt <= 8'h00;
	endtask : ev
	// Counts steps until the feed ends; samples the tick once at the start
	task fw(input logic [7:0] es, input logic [7:0] et);
		logic [7:0] s;
		logic [7:0] t;
		int k;
		s = 8'h00;
		t = 8'h00;
		k = 0;
		#1;
		t = t + {7'h00, tick_mark};
		while (feed_busy === 1'b1 && k < 2000)
		begin
			s = s + {7'h00, paper_step};
			@(posedge clk);
			#1;
			k++;
		end
		chk({7'h00, feed_busy}, 8'h00);
		chk(s, es);
		chk(t, et);
	endtask : fw
	// ====
	// Scenarios
	task t_margin;
		logic [7:0] mx [3];
		logic [7:0] cf [3];
		logic [7:0] p;
		mx = '{8'h28, 8'h50, 8'h84};
		cf = '{8'h05, 8'h01, 8'h09};
		p = 8'h50;
		rc(4'h1, 8'h50);
		rc(4'h0, 8'h01);
		for (int i = 0; i < 3; i++)
		begin
			wr(4'h0, cf[i]);
			ev(1, mx[i] + 8'h01);
			rc(4'h1, p);
			ev(1, mx[i]);
			rc(4'h1, mx[i]);
			p = mx[i];
		end
		wr(4'h2, 8'h14);
		ev(1, 8'h13);
		rc(4'h1, 8'h84);
		ev(1, 8'h14);
		rc(4'h1, 8'h14);
		wr(4'h2, 8'h01);
	endtask : t_margin
	task t_roll;
		wr(4'h0, 8'h00);
		rc(4'h3, 8'h48);
		rc(4'h4, 8'h00);
		ev(6, 8'h00);
		fw(8'h00, 8'h00);
		ev(4, 8'h01);
		ev(7, 8'h00);
		fw(8'h00, 8'h00);
		ev(2, 8'h01);
		rc(4'h0, 8'h02);
		rc(4'h3, 8'h41);
		rc(4'h4, 8'h02);
		rc(4'h5, 8'h3c);
		ev(3, 8'h00);
		rc(4'h3, 8'h41);
		ev(3, 8'hff);
		rc(4'h3, 8'hff);
		ev(4, 8'h9c);
		rc(4'h5, 8'h3c);
		ev(4, 8'h00);
		rc(4'h5, 8'h3c);
		ev(4, 8'h9b);
		rc(4'h5, 8'h9b);
		wr(4'h4, 8'hff);
		rc(4'h4, 8'hff);
		wr(4'h4, 8'h00);
		rc(4'h4, 8'h00);
		wr(4'h4, 8'h02);
	endtask : t_roll
	task t_pages;
		ev(5, 8'h00);
		rc(4'h7, 8'h01);
		ev(6, 8'h00);
		fw(8'h02, 8'h01);
		rc(4'h7, 8'h02);
		ev(4, 8'h02);
		ev(5, 8'h00);
		ev(5, 8'h00);
		ev(7, 8'h00);
		fw(8'h02, 8'h01);
		wr(4'h3, 8'h04);
		rc(4'h3, 8'h04);
		ev(5, 8'h00);
		ev(5, 8'h00);
		fw(8'h02, 8'h01);
		rc(4'h7, 8'h02);
		ev(2, 8'h00);
		rc(4'h0, 8'h00);
	endtask : t_pages
	task t_perf;
		wr(4'h0, 8'h01);
		wr(4'h4, 8'h00);
		rc(4'h4, 8'h02);
		hole_at <= 8'h05;
		ev(6, 8'h00);
		fw(8'h07, 8'h00);
		chk({7'h00, form_timeout}, 8'h00);
		ev(2, 8'h01);
		ev(6, 8'h00);
		fw(8'h07, 8'h00);
		ev(2, 8'h00);
		hole_at <= 8'h00;
		ev(6, 8'h00);
		fw(8'h48, 8'h00);
		chk({7'h00, form_timeout}, 8'h01);
		rc(4'h6, 8'h04);
		ev(0, 8'h00);
		rc(4'h0, 8'h01);
		rc(4'h1, 8'h50);
	endtask : t_perf
	initial
	begin
		#200000;
		fail_count++;
		summarize();
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_margin();
		t_roll();
		t_pages();
		t_perf();
		summarize();
	end
endmodule : pfc_page_format_tb
